// [bst_pkg.sv]
// Types for the boundary-scan test access port
package bst_pkg;
   typedef enum logic [3:0] {
      BST_TLR = 4'b0000, BST_RTI = 4'b0001, BST_SDR = 4'b0010, BST_CDR = 4'b0011,
      BST_SHDR = 4'b0100, BST_E1DR = 4'b0101, BST_PDR = 4'b0110, BST_E2DR = 4'b0111,
      BST_UDR = 4'b1000, BST_SIR = 4'b1001, BST_CIR = 4'b1010, BST_SHIR = 4'b1011,
      BST_E1IR = 4'b1100, BST_PIR = 4'b1101, BST_E2IR = 4'b1110, BST_UIR = 4'b1111
   } bst_state_t;
   typedef struct packed {
      logic test_mode_select;
      logic test_serial_in;
   } bst_link_t;
   typedef struct packed {
      logic test_serial_out;
      logic test_serial_out_oe;
   } bst_tdo_t;
endpackage

// [bst_regs.svh]
// Constants for the boundary-scan test access port
`ifndef BST_REGS_SVH
`define BST_REGS_SVH
`define BST_IR_W 3
`define BST_ID_W 32
`define BST_BSR_W 46
`define BST_OP_EXTEST 3'h0
`define BST_OP_IDCODE 3'h1
`define BST_OP_SAMPLE 3'h2
`define BST_OP_CLAMP 3'h3
`define BST_OP_HIGHZ 3'h4
`define BST_OP_BYPASS 3'h7
`define BST_IR_CAPTURE 3'h1
`define BST_ID_LSB_POS 0
`define BST_ID_MFR_POS 1
`define BST_ID_PART_POS 12
`define BST_ID_VER_POS 28
`endif

// [bst_tap.sv]
// Boundary-scan test access port: controller, instruction and data registers
`timescale 1ns/100ps
`include "bst_regs.svh"
// How it works
// - Every transition on test clock rise, branching on mode select.
// - Power-up enters test-logic-reset with identify instruction; system logic runs.
// - Select-DR holds registers; low to capture-DR, high to select-IR.
// - Capture-DR loads selected register if allowed; low shift, high exit1.
// - Shift-DR shifts selected register toward output; others hold.
// - Exit1-DR high update, low pause; pause holds until high to exit2.
// - Exit2-DR high to update-DR, low back to shift-DR.
// - Update-DR falling edge copies shift stages to parallel latches only.
// - Select-IR holds all; low to capture-IR, high to test-logic-reset.
// - Capture-IR loads fixed pattern; high exit1-IR, low shift-IR.
// - Shift-IR shifts instruction stages; others hold; high exits to exit1-IR.
// - Exit1-IR low pause, high update; pause-IR waits for high.
// - Exit2-IR high to update-IR; that clock's falling edge latches instruction.
// - Latched code becomes active; update-IR low idle, high select-DR.
// - Instruction register: three-bit shift section and three-bit latch.
// - Codes: 010 sample, 000 extest, 111 bypass via one-bit register.
// - Sample captures pins without disturbing operation; shift loads new data.
// - Extest drives outputs from boundary latches, captures inputs.
// - Clamp 011 drives outputs from boundary latches, bypass in path.
// - Highz 100 floats all outputs, bypass in path.
// - Identify 001 loads identity code at capture; reset forces it.
// - Identity: bit0 one, 11-bit maker, 16-bit part, 4-bit version.
// - Identify register 32-bit shift and latch; selected also in reset.
module bst_tap #(
   parameter logic [10:0] MFR_CODE = 11'h155,  // Arbitrary value
   parameter logic [15:0] PART_CODE = 16'h1234, // Arbitrary value
   parameter logic [3:0] VER_CODE = 4'h1        // Arbitrary value
) (
   input wire logic clk_i,
   input wire logic resetn_i,
   input wire logic test_clock,
   input wire logic test_reset_n,
   input wire logic test_mode_select,
   input wire logic test_serial_in,
   output logic test_serial_out,
   output logic test_serial_out_oe,
   input wire logic [`BST_BSR_W-1:0] pin_in_i,
   input wire logic [`BST_BSR_W-1:0] sys_out_i,
   output logic [`BST_BSR_W-1:0] pin_out_o,
   output logic pin_oe_n_o,
   output logic test_mode_o
);
   bst_pkg::bst_state_t state_r;
   bst_pkg::bst_state_t state_nxt;
   logic [`BST_IR_W-1:0] ir_sh_r;
   logic [`BST_IR_W-1:0] ir_r;
   logic [`BST_ID_W-1:0] id_sh_r;
   logic [`BST_ID_W-1:0] id_lat_r;
   logic [`BST_BSR_W-1:0] bsr_sh_r;
   logic [`BST_BSR_W-1:0] bsr_lat_r;
   logic byp_r;
   logic tdo_r;
   logic tdo_oe_r;
   logic [2:0] mode_sync_r;
   logic [2:0] hz_sync_r;
   logic mode_r;
   logic hz_r;

   // Identity code assembled from its fields
   wire [`BST_ID_W-1:0] id_code = {VER_CODE, PART_CODE, MFR_CODE, 1'b1};

   // Instruction decode; reset state forces identify as the active one
   wire in_tlr = (state_r == bst_pkg::BST_TLR);
   wire sel_bsr = (ir_r == `BST_OP_SAMPLE) || (ir_r == `BST_OP_EXTEST);
   wire sel_id = (ir_r == `BST_OP_IDCODE) || in_tlr;
   wire drive_pins = (ir_r == `BST_OP_EXTEST) || (ir_r == `BST_OP_CLAMP);
   wire float_pins = (ir_r == `BST_OP_HIGHZ);
   wire tms = test_mode_select;

   // Next state of the sixteen-state controller
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         // Reset holds while mode select stays high
         bst_pkg::BST_TLR: begin
            if (tms) begin
               state_nxt = bst_pkg::BST_TLR;
            end else begin
               state_nxt = bst_pkg::BST_RTI;
            end
         end
         // Idle between scans
         bst_pkg::BST_RTI: begin
            if (tms) begin
               state_nxt = bst_pkg::BST_SDR;
            end else begin
               state_nxt = bst_pkg::BST_RTI;
            end
         end
         // Data column entry
         bst_pkg::BST_SDR: begin
            if (tms) begin
               state_nxt = bst_pkg::BST_SIR;
            end else begin
               state_nxt = bst_pkg::BST_CDR;
            end
         end
         // One capture clock, then shift or skip ahead
         bst_pkg::BST_CDR: begin
            if (tms) begin
               state_nxt = bst_pkg::BST_E1DR;
            end else begin
               state_nxt = bst_pkg::BST_SHDR;
            end
         end
         // Shift as long as mode select stays low
         bst_pkg::BST_SHDR: begin
            if (tms) begin
               state_nxt = bst_pkg::BST_E1DR;
            end else begin
               state_nxt = bst_pkg::BST_SHDR;
            end
         end
         // Update or pause
         bst_pkg::BST_E1DR: begin
            if (tms) begin
               state_nxt = bst_pkg::BST_UDR;
            end else begin
               state_nxt = bst_pkg::BST_PDR;
            end
         end
         // Pause lets a slow tester refill its buffer
         bst_pkg::BST_PDR: begin
            if (tms) begin
               state_nxt = bst_pkg::BST_E2DR;
            end else begin
               state_nxt = bst_pkg::BST_PDR;
            end
         end
         // Resume shifting or finish
         bst_pkg::BST_E2DR: begin
            if (tms) begin
               state_nxt = bst_pkg::BST_UDR;
            end else begin
               state_nxt = bst_pkg::BST_SHDR;
            end
         end
         // Data update, then idle or next scan
         bst_pkg::BST_UDR: begin
            if (tms) begin
               state_nxt = bst_pkg::BST_SDR;
            end else begin
               state_nxt = bst_pkg::BST_RTI;
            end
         end
         // Instruction column entry, or back to reset
         bst_pkg::BST_SIR: begin
            if (tms) begin
               state_nxt = bst_pkg::BST_TLR;
            end else begin
               state_nxt = bst_pkg::BST_CIR;
            end
         end
         // Fixed pattern loads here
         bst_pkg::BST_CIR: begin
            if (tms) begin
               state_nxt = bst_pkg::BST_E1IR;
            end else begin
               state_nxt = bst_pkg::BST_SHIR;
            end
         end
         // Instruction shifting
         bst_pkg::BST_SHIR: begin
            if (tms) begin
               state_nxt = bst_pkg::BST_E1IR;
            end else begin
               state_nxt = bst_pkg::BST_SHIR;
            end
         end
         // Update or pause
         bst_pkg::BST_E1IR: begin
            if (tms) begin
               state_nxt = bst_pkg::BST_UIR;
            end else begin
               state_nxt = bst_pkg::BST_PIR;
            end
         end
         // Instruction pause
         bst_pkg::BST_PIR: begin
            if (tms) begin
               state_nxt = bst_pkg::BST_E2IR;
            end else begin
               state_nxt = bst_pkg::BST_PIR;
            end
         end
         // Low goes back to shifting, as on the usual diagram
         bst_pkg::BST_E2IR: begin
            if (tms) begin
               state_nxt = bst_pkg::BST_UIR;
            end else begin
               state_nxt = bst_pkg::BST_SHIR;
            end
         end
         // New instruction takes over on this state's falling edge
         bst_pkg::BST_UIR: begin
            if (tms) begin
               state_nxt = bst_pkg::BST_SDR;
            end else begin
               state_nxt = bst_pkg::BST_RTI;
            end
         end
         // Unreachable with a full enum; recover to reset anyway
         default: begin
            state_nxt = bst_pkg::BST_TLR;
         end
      endcase
   end

   // Controller register; test reset is asynchronous so a stuck clock still resets
   always_ff @(posedge test_clock or negedge test_reset_n) begin
      if (!test_reset_n) begin
         state_r <= bst_pkg::BST_TLR;
      end else begin
         state_r <= state_nxt;
      end
   end

   // Instruction shift stages: capture a fixed pattern, shift lsb first
   always_ff @(posedge test_clock) begin
      if (state_r == bst_pkg::BST_CIR) begin
         ir_sh_r <= `BST_IR_CAPTURE;
      end else if (state_r == bst_pkg::BST_SHIR) begin
         ir_sh_r <= {test_serial_in, ir_sh_r[`BST_IR_W-1:1]};
      end
   end

   // Active instruction latched on the falling edge in update-IR
   always_ff @(negedge test_clock or negedge test_reset_n) begin
      if (!test_reset_n) begin
         ir_r <= `BST_OP_IDCODE;
      end else if (in_tlr) begin
         ir_r <= `BST_OP_IDCODE;
      end else if (state_r == bst_pkg::BST_UIR) begin
         ir_r <= ir_sh_r;
      end
   end

   // Data register shift stages; unselected ones hold, pause and select states hold
   always_ff @(posedge test_clock) begin
      if (state_r == bst_pkg::BST_CDR) begin
         if (sel_id) begin
            id_sh_r <= id_code;
         end
         if (sel_bsr) begin
            bsr_sh_r <= pin_in_i;
         end
         if (!sel_id && !sel_bsr) begin
            byp_r <= 1'b0;
         end
      end else if (state_r == bst_pkg::BST_SHDR) begin
         if (sel_id) begin
            id_sh_r <= {test_serial_in, id_sh_r[`BST_ID_W-1:1]};
         end
         if (sel_bsr) begin
            bsr_sh_r <= {test_serial_in, bsr_sh_r[`BST_BSR_W-1:1]};
         end
         if (!sel_id && !sel_bsr) begin
            byp_r <= test_serial_in;
         end
      end
   end

   // Parallel latches follow shift stages only on the update-DR falling edge
   always_ff @(negedge test_clock) begin
      if (state_r == bst_pkg::BST_UDR) begin
         if (sel_bsr) begin
            bsr_lat_r <= bsr_sh_r;
         end
         if (sel_id) begin
            id_lat_r <= id_sh_r;
         end
      end
   end

   // Serial output changes on the falling edge, driven only while shifting
   always_ff @(negedge test_clock or negedge test_reset_n) begin
      if (!test_reset_n) begin
         tdo_r <= 1'b0;
         tdo_oe_r <= 1'b0;
      end else begin
         tdo_oe_r <= (state_r == bst_pkg::BST_SHDR) || (state_r == bst_pkg::BST_SHIR);
         if (state_r == bst_pkg::BST_SHIR) begin
            tdo_r <= ir_sh_r[0];
         end else if (sel_id) begin
            tdo_r <= id_sh_r[0];
         end else if (sel_bsr) begin
            tdo_r <= bsr_sh_r[0];
         end else begin
            tdo_r <= byp_r;
         end
      end
   end

   assign test_serial_out = tdo_r;
   assign test_serial_out_oe = tdo_oe_r;

   // Levels into the system domain: three stages, change accepted when last two agree
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         mode_sync_r <= 3'h0;
         hz_sync_r <= 3'h0;
         mode_r <= 1'b0;
         hz_r <= 1'b0;
      end else begin
         mode_sync_r <= {mode_sync_r[1:0], drive_pins};
         hz_sync_r <= {hz_sync_r[1:0], float_pins};
         if (mode_sync_r[2] == mode_sync_r[1]) begin
            mode_r <= mode_sync_r[2];
         end
         if (hz_sync_r[2] == hz_sync_r[1]) begin
            hz_r <= hz_sync_r[2];
         end
      end
   end

   // Per-pin source select; latched boundary data is static, so a slow crossing is harmless
   logic [`BST_BSR_W-1:0] pin_src;
   generate
      for (genvar g = 0; g < `BST_BSR_W; g++) begin : g_pin
         // Boundary latch owns the pin only in a driving test mode
         assign pin_src[g] = mode_r ? bsr_lat_r[g] : sys_out_i[g];
      end
   endgenerate

   // Pin register in the system domain
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         pin_out_o <= '0;
         pin_oe_n_o <= 1'b0;
      end else begin
         pin_out_o <= pin_src;
         pin_oe_n_o <= hz_r;
      end
   end

   assign test_mode_o = mode_r | hz_r;
endmodule

// [bst_tap_props.sv]
// Pin-level checker for the boundary-scan test access port
`timescale 1ns/100ps
`include "bst_regs.svh"
module bst_tap_props (
   input wire logic clk_i,
   input wire logic resetn_i,
   input wire logic test_clock,
   input wire logic test_reset_n,
   input wire logic test_mode_select,
   input wire logic test_serial_out,
   input wire logic test_serial_out_oe,
   input wire logic [`BST_BSR_W-1:0] sys_out_i,
   input wire logic [`BST_BSR_W-1:0] pin_out_o,
   input wire logic pin_oe_n_o,
   input wire logic test_mode_o
);
   // Five highs reach test-logic-reset from any state
   sequence s_reset;
      test_mode_select [*5];
   endsequence
   sequence s_to_shir;
      s_reset ##1 !test_mode_select ##1 test_mode_select [*2] ##1 !test_mode_select [*2];
   endsequence
   sequence s_to_shdr;
      s_reset ##1 !test_mode_select ##1 test_mode_select ##1 !test_mode_select [*2];
   endsequence
   // Link side: shift states are only entered on mode select low
   a_oe_off_tms: assert property (@(posedge test_clock) disable iff (!test_reset_n)
      test_mode_select |=> !test_serial_out_oe) else $error("serial out driven after exit");
   a_ir_capture: assert property (@(posedge test_clock) disable iff (!test_reset_n)
      s_to_shir |=> test_serial_out_oe && test_serial_out) else $error("bad capture bit");
   a_id_lsb: assert property (@(posedge test_clock) disable iff (!test_reset_n)
      s_to_shdr |=> test_serial_out_oe && test_serial_out) else $error("bad id lsb");
   a_idle_quiet: assert property (@(posedge test_clock) disable iff (!test_reset_n)
      s_reset ##1 !test_mode_select |=> !test_serial_out_oe) else $error("idle drives");
   // System side: pins follow the system unless a test mode owns them
   a_highz_mode: assert property (@(posedge clk_i) disable iff (!resetn_i)
      pin_oe_n_o |-> test_mode_o || $past(test_mode_o)) else $error("float outside test");
   a_pins_follow: assert property (@(posedge clk_i) disable iff (!resetn_i)
      (resetn_i && !test_mode_o) [*3] |-> pin_out_o == $past(sys_out_i))
      else $error("pins do not follow system");
   a_reset_mode: assert property (@(posedge clk_i) disable iff (!resetn_i)
      !test_reset_n [*8] |-> !test_mode_o) else $error("test mode kept in reset");
   a_oe_clear: assert property (@(posedge clk_i) disable iff (!resetn_i)
      !test_reset_n |=> !test_serial_out_oe) else $error("serial out driven in reset");
endmodule
bind bst_tap bst_tap_props i_props (.clk_i, .resetn_i, .test_clock, .test_reset_n,
   .test_mode_select, .test_serial_out, .test_serial_out_oe, .sys_out_i, .pin_out_o,
   .pin_oe_n_o, .test_mode_o);

// [bst_tester.sv]
// Tester model: drives test clock, mode select and serial in, samples serial out
`timescale 1ns/100ps
`include "bst_regs.svh"
module bst_tester (
   output logic test_clock,
   output logic test_mode_select,
   output logic test_serial_in,
   input wire logic test_serial_out
);
   initial begin
      test_clock = 1'b0;
      test_mode_select = 1'b1;
      test_serial_in = 1'b0;
   end
   // One 12 ns period; the clock rests low outside frames
   task automatic tick(input logic tms, input logic tdi, output logic tdo);
      test_mode_select = tms;
      test_serial_in = tdi;
      #6 test_clock = 1'b1;
      tdo = test_serial_out;
      #6 test_clock = 1'b0;
   endtask
   task automatic go_reset;
      logic b;
      repeat (5) tick(1'b1, 1'b0, b);
      tick(1'b0, 1'b0, b);
   endtask
   // From idle: scan n bits lsb first, update, back to idle
   task automatic scan(input logic is_ir, input int n, input logic [`BST_BSR_W-1:0] din,
      output logic [`BST_BSR_W-1:0] dout);
      logic b;
      dout = '0;
      tick(1'b1, 1'b0, b);
      if (is_ir) tick(1'b1, 1'b0, b);
      tick(1'b0, 1'b0, b);
      tick(1'b0, 1'b0, b);
      for (int i = 0; i < n; i++) tick(i == n - 1, din[i], dout[i]);
      tick(1'b1, 1'b0, b);
      tick(1'b0, 1'b0, b);
      // Idle serial line shows no stale value
      test_serial_in = ~test_serial_in;
   endtask
endmodule

// [tb_top.sv]
// Self-checking bench for the boundary-scan test access port
`timescale 1ns/100ps
`include "bst_regs.svh"
module tb_top;
   localparam logic [31:0] ID = {4'h3, 16'h5a5a, 11'h2aa, 1'b1}; // Codes are arbitrary
   logic clk_i, resetn_i, test_reset_n, test_clock, tms, tdi, tdo, tdo_oe, pin_oe_n_o, test_mode_o;
   logic [`BST_BSR_W-1:0] pin_in_i, sys_out_i, pin_out_o, d;
   int fails, n_compared;
   bst_tap #(.MFR_CODE(ID[11:1]), .PART_CODE(ID[27:12]), .VER_CODE(ID[31:28])) i_dut (
      .clk_i(clk_i), .resetn_i(resetn_i), .test_clock(test_clock), .test_reset_n(test_reset_n),
      .test_mode_select(tms), .test_serial_in(tdi), .test_serial_out(tdo),
      .test_serial_out_oe(tdo_oe), .pin_in_i(pin_in_i), .sys_out_i(sys_out_i),
      .pin_out_o(pin_out_o), .pin_oe_n_o(pin_oe_n_o), .test_mode_o(test_mode_o));
   bst_tester i_tst (.test_clock(test_clock), .test_mode_select(tms), .test_serial_in(tdi),
      .test_serial_out(tdo));
   task automatic chk(input string what, input logic [`BST_BSR_W-1:0] exp, got);
      n_compared++;
      if (got !== exp) begin
         fails++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask
   // Load an instruction, then let the pin side settle
   task automatic ir(input logic [2:0] code);
      i_tst.scan(1'b1, 3, {43'h0, code}, d);
      chk("ir capture", 46'h1, d);
      repeat (8) @(negedge clk_i);
   endtask
   task automatic t_ident;
      for (int k = 0; k < 2; k++) begin
         i_tst.go_reset();
         if (k == 1) ir(`BST_OP_IDCODE);
         i_tst.scan(1'b0, 32, '0, d);
         chk("idcode", {14'h0, ID}, d);
      end
   endtask
   // Bypass and unknown codes give a one-bit path and leave the pins alone
   task automatic t_bypass;
      logic [2:0] codes [3];
      codes = '{`BST_OP_BYPASS, 3'h5, 3'h6};
      foreach (codes[k]) begin
         ir(codes[k]);
         i_tst.scan(1'b0, 8, 46'hb5, d);
         chk("bypass", 46'h6a, d);
         chk("bypass pins", sys_out_i, pin_out_o);
      end
   endtask
   task automatic t_boundary;
      ir(`BST_OP_SAMPLE);
      i_tst.scan(1'b0, 46, 46'h3c3c_5a5a_0ff0, d);
      chk("sample", pin_in_i, d);
      chk("sample pins", sys_out_i, pin_out_o);
      ir(`BST_OP_EXTEST);
      chk("extest pins", 46'h3c3c_5a5a_0ff0, pin_out_o);
      pin_in_i = ~pin_in_i;
      i_tst.scan(1'b0, 46, 46'h0123_4567_89ab, d);
      repeat (8) @(negedge clk_i);
      chk("extest capture", pin_in_i, d);
      chk("update", 46'h0123_4567_89ab, pin_out_o);
      ir(`BST_OP_HIGHZ);
      chk("highz", 46'h1, {45'h0, pin_oe_n_o});
      ir(`BST_OP_CLAMP);
      chk("clamp", 46'h0123_4567_89ab, pin_out_o);
      chk("clamp drive", 46'h0, {45'h0, pin_oe_n_o});
      test_reset_n = 1'b0;
      repeat (8) @(negedge clk_i);
      test_reset_n = 1'b1;
      chk("released pins", sys_out_i, pin_out_o);
   endtask
   task automatic give_verdict;
      $display("Compared %0d mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end
   // Watchdog well beyond the roughly 300 test clocks the scans need
   initial begin
      #300000;
      fails++;
      give_verdict();
   end
   initial begin
      resetn_i = 1'b0;
      test_reset_n = 1'b0;
      pin_in_i = 46'h1234_5678_9abc;
      sys_out_i = 46'h2a5a_0f0f_33cc;
      repeat (20) @(negedge clk_i);
      resetn_i = 1'b1;
      test_reset_n = 1'b1;
      t_ident();
      t_bypass();
      t_boundary();
      give_verdict();
   end
endmodule
